/* core/tao_pkg.sv */
package tao_pkg;
  localparam int unsigned NCH   = 8;
  localparam int unsigned NSLOT = 10;
  localparam logic [11:0] IDX_GLOBAL_CTL = 12'h03B;
  localparam logic [11:0] IDX_STATUS     = 12'h03C;
  // Register offsets within a channel; index 0 is side A
  localparam logic [1:0][NSLOT-1:0][7:0] REG_OFF = {
    {8'hD6, 8'hD5, 8'hD4, 8'hD3, 8'hD2, 8'hD1, 8'hD0, 8'hCE, 8'hCD, 8'hCC},
    {8'h66, 8'h65, 8'h64, 8'h63, 8'h62, 8'h61, 8'h60, 8'h5E, 8'h5D, 8'h5C}};
  localparam logic [3:0] SL_TP_V1  = 4'h0;
  localparam logic [3:0] SL_TP_V2  = 4'h1;
  localparam logic [3:0] SL_V4     = 4'h2;
  localparam logic [3:0] SL_V5     = 4'h3;
  localparam logic [3:0] SL_N2     = 4'h4;
  localparam logic [3:0] SL_K4     = 4'h5;
  localparam logic [3:0] SL_CTL_ID = 4'h6;
  localparam logic [3:0] SL_CTL_OH = 4'h7;
  localparam logic [3:0] SL_CTL_K4 = 4'h8;
  localparam logic [3:0] SL_CTL_V4 = 4'h9;
  localparam int unsigned B_TC_EN  = 2;
  localparam int unsigned B_UQ_SUP = 3;
  localparam int unsigned B_UQ_EN  = 4;
  localparam int unsigned B_TP_SEL = 5;
  localparam int unsigned B_AIS    = 6;
  localparam int unsigned B_V5_SEL = 0;
  localparam int unsigned B_TCUQ   = 2;
  localparam int unsigned B_K4_SEL = 1;
  localparam int unsigned B_V4_SEL = 0;
  localparam int unsigned B_RDI3   = 6;
  localparam int unsigned B_VC12   = 7;
  localparam int unsigned B_BIP_DIS = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [9:0] PTR_VC11  = 10'd78;
  localparam logic [9:0] PTR_VC12  = 10'd105;
  localparam logic [3:0] NDF_NORM  = 4'h6;
  localparam logic [1:0] SIZE_VC11 = 2'h3;
  localparam logic [1:0] SIZE_VC12 = 2'h2;
  localparam logic [5:0] LEN_VC11  = 6'd27;
  localparam logic [5:0] LEN_VC12  = 6'd36;
  localparam logic [2:0] LABEL_NORMAL = 3'h2;
  localparam logic [7:0] J2_SUP    = 8'h01;
  localparam logic [7:0] AIS_BYTE  = 8'hFF;

  typedef struct packed {
    logic add_bus_byte_clock;
    logic add_bus_frame_marker;
    logic add_bus_payload_indication;
  } tao_bus_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic       add_bus_parity_out;
    logic       add_slot_indicator;
    logic       add_bus_byte_clock;
    logic       add_bus_frame_marker;
    logic       add_bus_payload_indication;
    logic       timing_oe;
  } tao_bus_out_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] channel;
  } tao_take_t;
endpackage

/* core/tao_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module tao_gen
  import tao_pkg::*;
(
  input  wire logic                  pclk,                // Bus clock
  input  wire logic                  presetn,             // Async reset
  input  wire logic                  psel,                // APB select
  input  wire logic                  penable,             // APB enable
  input  wire logic                  pwrite,              // APB direction
  input  wire logic [31:0]           paddr,               // APB address
  input  wire logic [31:0]           pwdata,              // APB write data
  output var  logic [31:0]           prdata,              // APB read data
  output var  logic                  pready,              // APB ready
  output var  logic                  pslverr,             // APB error
  input  wire tao_bus_in_t [1:0]     add_in,              // Add bus timing in
  input  wire tao_bus_in_t [1:0]     drop_in,             // Drop bus timing
  input  wire logic                  bus_timing_select_pin,      // Mode pin
  input  wire logic                  timing_output_tristate_pin, // Mode pin
  input  wire logic [1:0][7:0]       payload_byte,        // Payload per side
  input  wire logic [1:0][NCH-1:0]   rdi_req,             // RDI per channel
  input  wire logic [1:0][NCH-1:0]   rei_req,             // REI per channel
  output var  tao_bus_out_t [1:0]    add_out,             // Add bus outputs
  output var  tao_take_t [1:0]       payload_take         // Payload consumed
);

  typedef struct packed {
    logic [1:0][NCH-1:0][NSLOT-1:0][7:0] sw;
    logic [1:0][NCH-1:0][NSLOT-1:0][7:0] act;
    logic [7:0]                          gctl;
    tao_bus_in_t [1:0]                   sa1;
    tao_bus_in_t [1:0]                   sa2;
    tao_bus_in_t [1:0]                   sd1;
    tao_bus_in_t [1:0]                   sd2;
    logic [1:0]                          m1;
    logic [1:0]                          m2;
    logic [1:0]                          clk_prev;
    logic [1:0][2:0]                     ch;
    logic [1:0][NCH-1:0][5:0]            byt;
    logic [1:0][NCH-1:0][1:0]            frm;
    logic [1:0][NCH-1:0][1:0]            acc;
    logic [1:0][NCH-1:0][1:0]            last_bip;
    logic [1:0]                          aligned;
    tao_bus_out_t [1:0]                  bus;
    tao_take_t [1:0]                     take;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
  } tao_state_t;

  tao_state_t cur_ff;
  tao_state_t nxt_state;

  function automatic logic [1:0] bip_of(input logic [7:0] x);
    bip_of = {x[7] ^ x[5] ^ x[3] ^ x[1], x[6] ^ x[4] ^ x[2] ^ x[0]};
  endfunction

  // Returns {hit, side, slot} for a per-channel offset
  function automatic logic [5:0] lookup(input logic [7:0] off);
    lookup = 6'h00;
    for (int sd = 0; sd < 2; sd++) begin
      for (int sl = 0; sl < NSLOT; sl++) begin
        if (REG_OFF[sd][sl] == off) begin
          lookup = {1'b1, sd[0], sl[3:0]};
        end
      end
    end
  endfunction

  function automatic logic [7:0] gen_byte(
    input logic [NSLOT-1:0][7:0] r,
    input logic [1:0]            f,
    input logic [5:0]            b,
    input logic [1:0]            bip,
    input logic [1:0]            prev_bip,
    input logic                  bip_dis,
    input logic                  rdi,
    input logic                  rei,
    input logic [7:0]            pay
  );
    logic       ais;
    logic       uq;
    logic       sup;
    logic       tc;
    logic       vc12;
    logic [9:0] ptr;
    logic [7:0] v1;
    logic [7:0] tcb;
    logic [7:0] res;
    ais  = r[SL_CTL_ID][B_AIS];
    uq   = r[SL_CTL_ID][B_UQ_EN];
    sup  = uq & r[SL_CTL_ID][B_UQ_SUP];
    tc   = r[SL_CTL_ID][B_TC_EN];
    vc12 = r[SL_CTL_V4][B_VC12];
    ptr  = vc12 ? PTR_VC12 : PTR_VC11;
    v1   = {NDF_NORM, vc12 ? SIZE_VC12 : SIZE_VC11, ptr[9:8]};
    // TC byte: unequipped form or the normal TC byte with bit 5 set
    if (r[SL_CTL_OH][B_TCUQ]) begin
      tcb = bip_dis ? 8'h00 : {prev_bip, 6'h00};
    end else begin
      tcb = {prev_bip, 1'b1, 5'h00};
    end
    res = uq ? 8'h00 : pay;
    if (b == 6'd0) begin
      case (f)
        2'd0: begin
          // Test pointer relies on software clearing it in unequipped
          if (r[SL_CTL_ID][B_TP_SEL]) begin
            res = r[SL_TP_V1];
          end else begin
            res = v1;
          end
        end
        2'd1: begin
          if (r[SL_CTL_ID][B_TP_SEL]) begin
            res = r[SL_TP_V2];
          end else begin
            res = ptr[7:0];
          end
        end
        2'd2: begin
          res = 8'h00;
        end
        default: begin
          if (r[SL_CTL_V4][B_V4_SEL]) begin
            res = r[SL_V4];
          end else begin
            res = 8'h00;
          end
        end
      endcase
    end else if (b == 6'd1) begin
      case (f)
        2'd1: begin
          if (sup) begin
            res = {bip, rei, 1'b0, 3'h0, rdi};
          end else if (uq) begin
            res = {bip, 6'h00};
          end else if (r[SL_CTL_OH][B_V5_SEL]) begin
            res = r[SL_V5];
          end else begin
            res = {bip, rei, 1'b0, LABEL_NORMAL, rdi};
          end
        end
        2'd2: begin
          if (sup) begin
            res = J2_SUP;
          end else begin
            res = 8'h00;
          end
        end
        2'd3: begin
          if (sup) begin
            res = tc ? tcb : 8'h00;
          end else if (uq) begin
            res = 8'h00;
          end else begin
            if (tc) begin
              res = tcb;
            end else begin
              res = r[SL_N2];
            end
          end
        end
        default: begin
          if (sup) begin
            res = r[SL_CTL_V4][B_RDI3] ?
                  {4'h0, {3{rdi}}, 1'b0} : 8'h00;
          end else if (uq) begin
            res = 8'h00;
          end else begin
            if (r[SL_CTL_K4][B_K4_SEL]) begin
              res = r[SL_K4];
            end else begin
              res = 8'h00;
            end
          end
        end
      endcase
    end
    if (ais) begin
      res = AIS_BYTE;
    end
    gen_byte = res;
  endfunction

  always_comb begin
    tao_bus_in_t              tin;
    logic                     clk_now;
    logic                     drop_mode;
    logic [2:0]               c;
    logic [1:0]               f;
    logic [5:0]               b;
    logic [5:0]               len;
    logic [NSLOT-1:0][7:0]    r;
    logic [7:0]               res;
    logic [11:0]              idx;
    logic [5:0]               lk;
    logic                     hit;
    logic                     ghit;
    logic                     uq_ais;
    tin       = '0;
    clk_now   = 1'b0;
    drop_mode = 1'b0;
    c         = 3'h0;
    f         = 2'h0;
    b         = 6'h00;
    len       = LEN_VC11;
    r         = '0;
    res       = 8'h00;
    idx       = 12'h000;
    lk        = 6'h00;
    hit       = 1'b0;
    ghit      = 1'b0;
    uq_ais    = 1'b0;
    nxt_state = cur_ff;
    // Pin synchronisers
    nxt_state.sa1 = add_in;
    nxt_state.sa2 = cur_ff.sa1;
    nxt_state.sd1 = drop_in;
    nxt_state.sd2 = cur_ff.sd1;
    nxt_state.m1  = {timing_output_tristate_pin, bus_timing_select_pin};
    nxt_state.m2  = cur_ff.m1;
    drop_mode     = cur_ff.m2[0];

    for (int s = 0; s < 2; s++) begin
      tin = drop_mode ? cur_ff.sd2[s] : cur_ff.sa2[s];
      clk_now = tin.add_bus_byte_clock;
      nxt_state.clk_prev[s] = clk_now;
      nxt_state.take[s] = '0;
      // Timing copies from the drop bus; held low while released so
      // the undriven pins do not toggle
      nxt_state.bus[s].timing_oe =
        drop_mode & ~cur_ff.m2[1];
      if (drop_mode & ~cur_ff.m2[1]) begin
        nxt_state.bus[s].add_bus_byte_clock =
          cur_ff.sd2[s].add_bus_byte_clock;
        nxt_state.bus[s].add_bus_frame_marker =
          cur_ff.sd2[s].add_bus_frame_marker;
        nxt_state.bus[s].add_bus_payload_indication =
          cur_ff.sd2[s].add_bus_payload_indication;
      end else begin
        nxt_state.bus[s].add_bus_byte_clock         = 1'b0;
        nxt_state.bus[s].add_bus_frame_marker       = 1'b0;
        nxt_state.bus[s].add_bus_payload_indication = 1'b0;
      end
      if (clk_now & ~cur_ff.clk_prev[s]) begin
        if (tin.add_bus_payload_indication) begin
          c = cur_ff.ch[s];
          f = cur_ff.frm[s][c];
          b = cur_ff.byt[s][c];
          // V1 marker restarts the multiframe for every channel
          if (tin.add_bus_frame_marker) begin
            c = 3'h0;
            f = 2'h0;
            b = 6'h00;
            for (int k = 0; k < NCH; k++) begin
              nxt_state.frm[s][k] = 2'h0;
              nxt_state.byt[s][k] = 6'h00;
            end
            nxt_state.aligned[s] = 1'b1;
          end
          if ((f == 2'd0) && (b == 6'd0)) begin
            r = cur_ff.sw[s][c];
            nxt_state.act[s][c] = cur_ff.sw[s][c];
          end else begin
            r = cur_ff.act[s][c];
          end
          res = gen_byte(r, f, b, cur_ff.acc[s][c], cur_ff.last_bip[s][c],
                         cur_ff.gctl[B_BIP_DIS], rdi_req[s][c], rei_req[s][c],
                         payload_byte[s]);
          // BIP-2 covers V5 up to the next V5, skipping the V1-V4 bytes
          if ((f == 2'd1) && (b == 6'd1)) begin
            nxt_state.acc[s][c] = bip_of(res);
            nxt_state.last_bip[s][c] = cur_ff.acc[s][c];
          end else if (b != 6'd0) begin
            nxt_state.acc[s][c] = cur_ff.acc[s][c] ^ bip_of(res);
          end
          len = r[SL_CTL_V4][B_VC12] ? LEN_VC12 : LEN_VC11;
          if (b >= len - 6'd1) begin
            nxt_state.byt[s][c] = 6'h00;
            nxt_state.frm[s][c] = f + 2'd1;
          end else begin
            nxt_state.byt[s][c] = b + 6'd1;
            nxt_state.frm[s][c] = f;
          end
          nxt_state.ch[s] = c + 3'd1;
          uq_ais = r[SL_CTL_ID][B_UQ_EN] | r[SL_CTL_ID][B_AIS];
          nxt_state.take[s].valid = (b > 6'd1) & ~uq_ais;
          nxt_state.take[s].channel = c;
          nxt_state.bus[s].data = res;
          nxt_state.bus[s].add_slot_indicator = 1'b1;
        end else begin
          nxt_state.bus[s].data = 8'h00;
          nxt_state.bus[s].add_slot_indicator = 1'b0;
        end
        nxt_state.bus[s].add_bus_parity_out =
          ~^nxt_state.bus[s].data;
      end
    end

    // APB slave: no wait states, registered answer
    idx  = paddr[13:2];
    lk   = lookup(idx[7:0]);
    hit  = (paddr[31:14] == 18'h0) & ~idx[11] & lk[5];
    ghit = (paddr[31:14] == 18'h0) &
           ((idx == IDX_GLOBAL_CTL) | (idx == IDX_STATUS));
    nxt_state.pready  = psel & ~penable;
    nxt_state.prdata  = 32'h0;
    nxt_state.pslverr = 1'b0;
    if (psel & ~penable) begin
      nxt_state.pslverr = ~(hit | ghit);
      if (ghit & (idx == IDX_GLOBAL_CTL)) begin
        nxt_state.prdata = {24'h0, cur_ff.gctl};
      end else if (ghit & (idx == IDX_STATUS)) begin
        nxt_state.prdata = {28'h0, cur_ff.aligned, cur_ff.m2};
      end else if (hit) begin
        nxt_state.prdata = {24'h0, cur_ff.sw[lk[4]][idx[10:8]][lk[3:0]]};
      end else begin
        nxt_state.prdata = 32'h0;
      end
    end
    if (psel & penable & cur_ff.pready & pwrite) begin
      if (ghit & (idx == IDX_GLOBAL_CTL)) begin
        nxt_state.gctl = pwdata[7:0];
      end else if (hit) begin
        nxt_state.sw[lk[4]][idx[10:8]][lk[3:0]] = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign prdata       = cur_ff.prdata;
  assign pready       = cur_ff.pready;
  assign pslverr      = cur_ff.pslverr;
  assign add_out      = cur_ff.bus;
  assign payload_take = cur_ff.take;

endmodule
`default_nettype wire

/* verification/tao_gen_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module tao_mon
  import tao_pkg::*;
(
  input wire logic               pclk,     // Bus clock
  input wire logic               presetn,  // Async reset
  input wire logic               psel,     // APB select
  input wire logic               penable,  // APB enable
  input wire logic [31:0]        prdata,   // APB read data
  input wire logic               pready,   // APB ready
  input wire logic               pslverr,  // APB error
  input wire logic               bus_timing_select_pin,      // Mode pin
  input wire logic               timing_output_tristate_pin, // Mode pin
  input wire tao_bus_out_t [1:0] add_out,      // Add bus outputs
  input wire tao_bus_in_t [1:0]  drop_in,      // Drop bus timing
  input wire tao_take_t [1:0]    payload_take  // Payload consumed
);
  logic [1:0] oe;
  assign oe = {add_out[1].timing_oe, add_out[0].timing_oe};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // Six cycles cover the pin synchronisers
  sequence s_add_mode;
    (!bus_timing_select_pin) [*6];
  endsequence
  a_apb_ready_after: assert property (s_setup |=> s_access)
    else $error("no ready after setup");
  a_apb_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_apb_refused_zero: assert property (pready && pslverr |-> prdata == '0)
    else $error("refused read not zero");
  a_add_mode_release: assert property (
    s_add_mode |-> oe == 2'h0) else $error("timing driven in add mode");
  a_drop_mode_drive: assert property (
    (bus_timing_select_pin && !timing_output_tristate_pin) [*6]
    |-> oe == 2'h3) else $error("timing not driven in drop mode");
  a_tristate_release: assert property (
    (bus_timing_select_pin && timing_output_tristate_pin) [*6]
    |-> oe == 2'h0) else $error("timing driven while released");
  a_parity_odd_a: assert property (
    add_out[0].add_slot_indicator
    |-> ^{add_out[0].data, add_out[0].add_bus_parity_out})
    else $error("add parity not odd");
  a_idle_slot_zero: assert property (
    !add_out[1].add_slot_indicator |-> add_out[1].data == 8'h00)
    else $error("idle slot data not zero");
  a_drop_timing_copy: assert property (
    oe[0] |-> {add_out[0].add_bus_byte_clock, add_out[0].add_bus_frame_marker,
    add_out[0].add_bus_payload_indication} == $past(drop_in[0], 3))
    else $error("timing copy differs from drop bus");
  a_released_quiet: assert property (
    !oe[0] |-> {add_out[0].add_bus_byte_clock, add_out[0].add_bus_frame_marker,
    add_out[0].add_bus_payload_indication} == 3'h0)
    else $error("released timing outputs toggle");
  a_take_in_slot: assert property (
    payload_take[0].valid |-> add_out[0].add_slot_indicator
    ##1 !payload_take[0].valid) else $error("payload take outside a slot");
endmodule
bind tao_gen tao_mon u_tao_mon (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .bus_timing_select_pin, .timing_output_tristate_pin, .add_out, .drop_in,
  .payload_take
);
`default_nettype wire

/* verification/tao_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tao_bus_model
  import tao_pkg::*;
#(
  parameter int unsigned PERIOD = 960, // Slots from marker to marker
  parameter realtime     SKEW   = 1.3  // Phase offset in ns
)(
  output var tao_bus_in_t bus // Timing towards the block
);
  int unsigned slot;
  initial begin
    bus = '0;
    slot = 0;
    #(SKEW);
    // One slot in ten carries no payload
    forever begin
      bus.add_bus_frame_marker <= (slot == 0);
      bus.add_bus_payload_indication <= (slot % 10 != 9);
      bus.add_bus_byte_clock <= 1'b1;
      #32 bus.add_bus_byte_clock <= 1'b0;
      #32 slot = (slot + 1) % PERIOD;
    end
  end
endmodule
`default_nettype wire

/* verification/tao_gen_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tao_gen_tb_top
  import tao_pkg::*;
;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [31:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  tao_bus_in_t         am;
  tao_bus_in_t         dm;
  logic                sel;
  logic                hiz;
  logic [1:0][7:0]     pay;
  logic [1:0][NCH-1:0] rdi;
  logic [1:0][NCH-1:0] rei;
  tao_bus_out_t [1:0]  add_out;
  logic [7:0]          r[6];
  logic [33:0]         aq[$];
  logic [26:0]         dq[$];
  int                  k;
  int                  fail_count;
  int                  cmp_count;
  integer              seed = 32'h9A3462E8;
  tao_gen u_tao_gen (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .add_in({am, am}), .drop_in({dm, dm}),
    .bus_timing_select_pin(sel), .timing_output_tristate_pin(hiz),
    .payload_byte(pay), .rdi_req(rdi), .rei_req(rei), .add_out,
    .payload_take()
  );
  tao_bus_model #(.SKEW(1.3)) u_tao_bus_model_a (.bus(am));
  tao_bus_model #(.SKEW(23.7)) u_tao_bus_model_d (.bus(dm));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    pay <= 16'($random(seed));
    rdi <= 16'($random(seed));
    rei <= 16'($random(seed));
  end
  function automatic logic [31:0] adr(input logic [2:0] c, input int d, s);
    return {19'h0, c, REG_OFF[d][s], 2'h0};
  endfunction
  task automatic apb(input logic w, input logic [31:0] a, d,
                     input logic [33:0] e);
    int n = 0;
    aq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [31:0] a, v);
    apb(1'b0, a, 32'h0, {2'h1, v});
  endtask
  task automatic cfg(input logic [2:0] c, input logic [31:0] t);
    for (int s = 0; s < 10; s++)
      wr(adr(c, 0, s), 32'(s < 6 ? r[s] : t[8 * (s - 6) +: 8]));
  endtask
  task automatic ex(input logic [2:0] c, input logic [1:0] f,
                    input logic [5:0] b, input logic [7:0] v,
                    input logic [7:0] m = 8'hFF);
    dq.push_back({c, f, b, m, v & m});
  endtask
  task automatic cmp_apb(input logic [33:0] e);
    cmp_count++;
    if (pslverr !== e[33] || (e[32] && prdata !== e[31:0])) begin
      fail_count++;
      $display("ERROR %0t register answer mismatch", $time);
    end
  endtask
  task automatic cmp_byte(input logic [26:0] e);
    cmp_count++;
    if ((add_out[0].data & e[15:8]) !== e[7:0]) begin
      fail_count++;
      $display("ERROR %0t add byte mismatch at %h", $time, e[26:16]);
    end
  endtask
  task automatic end_sim;
    fail_count += dq.size() + aq.size();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && aq.size() > 0)
      cmp_apb(aq.pop_front());
  // Payload slot k after the marker serves channel k mod 8
  always @(negedge am.add_bus_byte_clock) begin
    if (am.add_bus_frame_marker)
      k = 0;
    if (add_out[0].add_slot_indicator === 1'b1 && !sel) begin
      if (dq.size() > 0 && dq[0][26:16] ===
          {k[2:0], 2'((k / 8) % 108 / 27), 6'((k / 8) % 27)})
        cmp_byte(dq.pop_front());
      k++;
    end
  end
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    end_sim();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sel = 1'b0;
    hiz = 1'b0;
    pay = '0;
    rdi = '0;
    rei = '0;
    k = 0;
    fail_count = 0;
    cmp_count = 0;
    foreach (r[i])
      r[i] = 8'($random(seed));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int s = 0; s < 10; s++)
      rd(adr(6, 0, s), 32'(REG_RESET));
    for (int s = 0; s < 10; s++)
      wr(adr(7, 1, s), 32'(r[s % 6]));
    for (int s = 0; s < 10; s++)
      rd(adr(7, 1, s), 32'(r[s % 6]));
    apb(1'b1, 32'h140, 32'hFF, 34'h2_0000_0000);
    apb(1'b0, 32'h140, 32'h0, 34'h3_0000_0000);
    cfg(0, 32'h01020120);
    cfg(1, 32'h00020110);
    cfg(2, 32'h00000050);
    cfg(3, 32'h00000418);
    cfg(5, 32'h00000404);
    cfg(4, 32'h80000004);
    cfg(6, 32'h4000001C);
    @(posedge am.add_bus_frame_marker);
    ex(0, 0, 0, r[0]);
    ex(1, 0, 0, 8'h6C);
    ex(2, 0, 0, 8'hFF);
    ex(3, 0, 0, 8'h6C);
    ex(4, 0, 0, 8'h68);
    ex(0, 0, 1, r[5]);
    ex(1, 0, 1, 8'h00);
    ex(3, 0, 1, 8'h00);
    ex(6, 0, 1, 8'h00, 8'hF1);
    ex(1, 0, 2, 8'h00);
    ex(0, 1, 0, r[1]);
    ex(1, 1, 0, 8'h4E);
    ex(0, 1, 1, r[3]);
    ex(1, 1, 1, 8'h00, 8'h3F);
    ex(3, 1, 1, 8'h00, 8'h1E);
    // VC-12 channel 4 reaches V2 after 36 slots, keyed as 27 + 9
    ex(4, 1, 9, 8'h69);
    ex(3, 2, 1, J2_SUP);
    ex(0, 3, 0, r[2]);
    ex(1, 3, 0, 8'h00);
    ex(2, 3, 0, 8'hFF);
    ex(0, 3, 1, r[4]);
    ex(1, 3, 1, 8'h00);
    ex(3, 3, 1, 8'h00);
    ex(5, 3, 1, 8'h00, 8'h3F);
    ex(6, 3, 1, 8'h20, 8'h3F);
    while (dq.size() > 0)
      @(posedge pclk);
    @(posedge am.add_bus_frame_marker);
    @(posedge pclk);
    wr(32'hEC, 32'h4);
    wr(adr(2, 0, 6), 32'h10);
    @(posedge am.add_bus_frame_marker);
    ex(2, 0, 0, 8'h6C);
    ex(5, 3, 1, 8'h00);
    while (dq.size() > 0)
      @(posedge pclk);
    rd(32'hEC, 32'h4);
    rd(32'hF0, 32'hC);
    sel <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(32'hF0, 32'hD);
    hiz <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(32'hF0, 32'hF);
    sel <= 1'b0;
    repeat (40) @(posedge pclk);
    end_sim();
  end
endmodule
`default_nettype wire
